// ---- dmacra_pkg.sv ----
package dmacra_pkg;
  // Register byte offsets
  localparam logic [5:0] ADDR_CTRL      = 6'h00;
  localparam logic [5:0] ADDR_REQ_SEL   = 6'h04;
  localparam logic [5:0] ADDR_PRI_HIGH  = 6'h08;
  localparam logic [5:0] ADDR_PRI_LOW   = 6'h0C;
  localparam logic [5:0] ADDR_SEC_HIGH  = 6'h10;
  localparam logic [5:0] ADDR_SEC_LOW   = 6'h14;
  localparam logic [5:0] ADDR_PERIPH    = 6'h18;
  localparam logic [5:0] ADDR_COUNT     = 6'h1C;
  localparam logic [5:0] ADDR_LAST_HIGH = 6'h20;
  localparam logic [5:0] ADDR_LAST_LOW  = 6'h24;
  localparam logic [5:0] ADDR_STATUS    = 6'h28;
  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DIR_BIT    = 1;
  localparam int CTRL_MODE_LSB   = 2;
  localparam int REQ_FORCE_BIT   = 15;
  localparam int SEL_W           = 8;
  localparam int ADDR_W          = 24;
  localparam int PAD_W           = 16;
  localparam int CNT_W           = 14;
  // Reset values
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Operating modes
  localparam logic [1:0] MODE_CONT      = 2'b00;
  localparam logic [1:0] MODE_ONESHOT   = 2'b01;
  localparam logic [1:0] MODE_CONT_PP   = 2'b10;
  localparam logic [1:0] MODE_ONESHOT_PP = 2'b11;
  // Peripheral request codes and their event index
  localparam int NUM_EVENTS = 23;
  localparam logic [7:0] SEL_CODE [NUM_EVENTS] = '{
    8'h00, 8'h01, 8'h05, 8'h25, 8'h26,
    8'h02, 8'h06, 8'h19, 8'h1A,
    8'h07, 8'h08, 8'h1B, 8'h1C,
    8'h0B, 8'h0C, 8'h1E, 8'h1F,
    8'h22, 8'h46, 8'h37, 8'h47,
    8'hFF, 8'hFF};
  localparam int NUM_LISTED = 21;
  typedef enum logic [1:0] {DMACRA_IDLE, DMACRA_READ, DMACRA_WRITE} dmacra_xfer_e;
endpackage : dmacra_pkg

// ---- dmacra_channel.sv ----
`timescale 1ns/100ps
// Functional notes
// - Set trigger: exactly one forced transfer
// - Otherwise selected peripheral request starts transfers
// - Writing zero to trigger does nothing
// - Trigger clears on completion or disable
// - Codes for interrupt zero, captures, compares
// - Codes for timers two to five
// - Codes for both serial ports
// - Codes for both CAN controllers
// - Selector bits 14-8 read zero
// - Primary 24-bit start address, split high/low
// - Secondary 24-bit start address, split high/low
// - 16-bit peripheral-side address register
// - 14-bit count; block is count plus one
// - Read-only last RAM address, zero at reset
// - Channel enable gates all transfer activity; other-channel RAM addresses are captured regardless
// - Direction bit picks RAM-to-peripheral or reverse
// - Ping-pong alternates primary and secondary addresses
module dmacra_channel
  import dmacra_pkg::*;
#(
  parameter int EVENT_W = 23
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic [5:0]           s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [5:0]           s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire logic [EVENT_W-1:0]   periph_event_i,
  input  wire logic                 other_ram_access_i,
  input  wire logic [dmacra_pkg::ADDR_W-1:0] other_ram_addr_i,
  output logic                      mem_req_o,
  output logic                      mem_write_o,
  output logic                      mem_is_ram_o,
  output logic [dmacra_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [15:0]               mem_wdata_o,
  input  wire logic                 mem_ack_i,
  input  wire logic [15:0]          mem_rdata_i,
  output logic                      block_done_o,
  output logic                      busy_o
);
  import dmacra_pkg::*;

  if (EVENT_W != NUM_EVENTS) begin : g_event_w_check
    $error("EVENT_W must equal NUM_EVENTS");
  end

  // Registers
  logic                  enable_ff;
  logic                  dir_ff;
  logic [1:0]            mode_ff;
  logic                  force_ff;
  logic [SEL_W-1:0]      sel_ff;
  logic [ADDR_W-1:0]     pri_ff;
  logic [ADDR_W-1:0]     sec_ff;
  logic [ADDR_W-1:0]     last_ff;
  logic [PAD_W-1:0]      pad_ff;
  logic [CNT_W-1:0]      cnt_ff;
  // Transfer engine
  dmacra_xfer_e          state_ff;
  logic [CNT_W-1:0]      done_ff;
  logic                  pp_sel_ff;
  logic                  pending_ff;
  logic                  forced_xfer_ff;
  logic                  stopped_ff;
  logic [15:0]           data_ff;
  logic                  req_prev_ff;
  // Bus
  logic                  aw_ff;
  logic                  w_ff;
  logic [5:0]            awaddr_ff;
  logic [31:0]           wdata_ff;
  logic [3:0]            wstrb_ff;

  // Request selection
  logic req_level;
  logic req_edge;
  always_comb begin
    req_level = 1'b0;
    for (int i = 0; i < NUM_LISTED; i++) begin
      if (sel_ff == SEL_CODE[i] && periph_event_i[i]) req_level = 1'b1;
    end
  end
  assign req_edge = req_level && !req_prev_ff;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_prev_ff <= 1'b0;
    end else begin
      req_prev_ff <= req_level;
    end
  end

  // AXI write channel
  logic wr_fire;
  assign wr_fire = aw_ff && w_ff && !s_axi_bvalid_o;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 6'h00;
      wdata_ff  <= RESET_ZERO;
      wstrb_ff  <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      s_axi_awready_o <= !aw_ff && !s_axi_awready_o && !s_axi_bvalid_o;
      s_axi_wready_o  <= !w_ff && !s_axi_wready_o && !s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_ff          <= 1'b0;
        w_ff           <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (awaddr_ff[1:0] == 2'b00 && awaddr_ff <= ADDR_COUNT) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Byte-lane merge for a 16-bit register image
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = old;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction : merge16

  logic wr_ctrl;
  logic wr_req;
  logic wr_ph;
  logic wr_pl;
  logic wr_sh;
  logic wr_sl;
  logic wr_pad;
  logic wr_cnt;
  assign wr_ctrl = wr_fire && awaddr_ff == ADDR_CTRL;
  assign wr_req  = wr_fire && awaddr_ff == ADDR_REQ_SEL;
  assign wr_ph   = wr_fire && awaddr_ff == ADDR_PRI_HIGH;
  assign wr_pl   = wr_fire && awaddr_ff == ADDR_PRI_LOW;
  assign wr_sh   = wr_fire && awaddr_ff == ADDR_SEC_HIGH;
  assign wr_sl   = wr_fire && awaddr_ff == ADDR_SEC_LOW;
  assign wr_pad  = wr_fire && awaddr_ff == ADDR_PERIPH;
  assign wr_cnt  = wr_fire && awaddr_ff == ADDR_COUNT;

  logic [15:0] req_new;
  assign req_new = merge16({force_ff, 7'h00, sel_ff}, wdata_ff, wstrb_ff);
  logic [15:0] cnt_new;
  assign cnt_new = merge16({2'b00, cnt_ff}, wdata_ff, wstrb_ff);

  // Configuration registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_ff <= 1'b0;
      dir_ff    <= 1'b0;
      mode_ff   <= MODE_CONT;
      sel_ff    <= '0;
      pri_ff    <= '0;
      sec_ff    <= '0;
      pad_ff    <= '0;
      cnt_ff    <= '0;
    end else begin
      if (wr_ctrl && wstrb_ff[0]) begin
        enable_ff <= wdata_ff[CTRL_ENABLE_BIT];
        dir_ff    <= wdata_ff[CTRL_DIR_BIT];
        mode_ff   <= wdata_ff[CTRL_MODE_LSB +: 2];
      end else if (stopped_ff) begin
        enable_ff <= 1'b0;
      end
      if (wr_req) sel_ff <= req_new[SEL_W-1:0];
      if (wr_ph && wstrb_ff[0]) pri_ff[23:16] <= wdata_ff[7:0];
      if (wr_pl) pri_ff[15:0] <= merge16(pri_ff[15:0], wdata_ff, wstrb_ff);
      if (wr_sh && wstrb_ff[0]) sec_ff[23:16] <= wdata_ff[7:0];
      if (wr_sl) sec_ff[15:0] <= merge16(sec_ff[15:0], wdata_ff, wstrb_ff);
      if (wr_pad) pad_ff <= merge16(pad_ff, wdata_ff, wstrb_ff);
      if (wr_cnt) cnt_ff <= cnt_new[CNT_W-1:0];
    end
  end

  // Manual trigger: settable only, cleared by hardware
  logic force_done;
  assign force_done = state_ff == DMACRA_WRITE && mem_req_o && mem_ack_i && forced_xfer_ff;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      force_ff <= 1'b0;
    end else if (!enable_ff) begin
      force_ff <= 1'b0;
    end else if (wr_req && req_new[REQ_FORCE_BIT]) begin
      force_ff <= 1'b1;
    end else if (force_done) begin
      force_ff <= 1'b0;
    end
  end

  // Transfer engine
  logic [ADDR_W-1:0] ram_addr;
  logic              ram_read_phase;
  logic              start_ok;
  assign ram_addr = (pp_sel_ff ? sec_ff : pri_ff) + {{(ADDR_W-CNT_W){1'b0}}, done_ff};
  assign ram_read_phase = dir_ff;
  assign start_ok = enable_ff && state_ff == DMACRA_IDLE && !stopped_ff;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff       <= DMACRA_IDLE;
      done_ff        <= '0;
      pp_sel_ff      <= 1'b0;
      pending_ff     <= 1'b0;
      forced_xfer_ff <= 1'b0;
      stopped_ff     <= 1'b0;
      data_ff        <= 16'h0000;
      block_done_o   <= 1'b0;
    end else begin
      block_done_o <= 1'b0;
      stopped_ff   <= 1'b0;
      if (!enable_ff) begin
        state_ff   <= DMACRA_IDLE;
        done_ff    <= '0;
        pp_sel_ff  <= 1'b0;
        pending_ff <= 1'b0;
      end else begin
        // A request during a transfer is kept once
        if (!force_ff && req_edge) pending_ff <= 1'b1;
        unique case (state_ff)
          DMACRA_IDLE: begin
            if (start_ok && force_ff && !forced_xfer_ff) begin
              state_ff       <= DMACRA_READ;
              forced_xfer_ff <= 1'b1;
            end else if (start_ok && !force_ff && (pending_ff || req_edge)) begin
              state_ff   <= DMACRA_READ;
              pending_ff <= 1'b0;
            end
          end
          DMACRA_READ: begin
            // Acks count only against an open request
            if (mem_req_o && mem_ack_i) begin
              data_ff  <= mem_rdata_i;
              state_ff <= DMACRA_WRITE;
            end
          end
          DMACRA_WRITE: begin
            if (mem_req_o && mem_ack_i) begin
              state_ff       <= DMACRA_IDLE;
              forced_xfer_ff <= 1'b0;
              if (done_ff == cnt_ff) begin
                done_ff      <= '0;
                block_done_o <= 1'b1;
                if (mode_ff[1]) pp_sel_ff <= !pp_sel_ff;
                if (mode_ff[0] && (!mode_ff[1] || pp_sel_ff)) stopped_ff <= 1'b1;
              end else begin
                done_ff <= done_ff + 1'b1;
              end
            end
          end
          default: state_ff <= DMACRA_IDLE;
        endcase
      end
    end
  end

  // Memory-side outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_req_o    <= 1'b0;
      mem_write_o  <= 1'b0;
      mem_is_ram_o <= 1'b0;
      mem_addr_o   <= '0;
      mem_wdata_o  <= 16'h0000;
      busy_o       <= 1'b0;
    end else begin
      busy_o <= state_ff != DMACRA_IDLE;
      if (state_ff == DMACRA_READ && !(mem_req_o && mem_ack_i)) begin
        mem_req_o    <= 1'b1;
        mem_write_o  <= 1'b0;
        mem_is_ram_o <= ram_read_phase;
        mem_addr_o   <= ram_read_phase ? ram_addr : {8'h00, pad_ff};
      end else if (state_ff == DMACRA_WRITE && !(mem_req_o && mem_write_o && mem_ack_i)) begin
        mem_req_o    <= 1'b1;
        mem_write_o  <= 1'b1;
        mem_is_ram_o <= !ram_read_phase;
        mem_addr_o   <= ram_read_phase ? {8'h00, pad_ff} : ram_addr;
        // Read word captured at its ack; bus data may move afterwards
        mem_wdata_o  <= data_ff;
      end else begin
        mem_req_o <= 1'b0;
      end
    end
  end

  // Most recent RAM address
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    // Own access wins when both fall in one cycle
    if (!rst_n_i) begin
      last_ff <= '0;
    end else if (mem_req_o && mem_ack_i && mem_is_ram_o) begin
      last_ff <= mem_addr_o;
    end else if (other_ram_access_i) begin
      last_ff <= other_ram_addr_i;
    end
  end

  // AXI read channel
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_mux = RESET_ZERO;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr_i)
      ADDR_CTRL:      rd_mux = {28'h0, mode_ff, dir_ff, enable_ff};
      ADDR_REQ_SEL:   rd_mux = {16'h0, force_ff, 7'h00, sel_ff};
      ADDR_PRI_HIGH:  rd_mux = {24'h0, pri_ff[23:16]};
      ADDR_PRI_LOW:   rd_mux = {16'h0, pri_ff[15:0]};
      ADDR_SEC_HIGH:  rd_mux = {24'h0, sec_ff[23:16]};
      ADDR_SEC_LOW:   rd_mux = {16'h0, sec_ff[15:0]};
      ADDR_PERIPH:    rd_mux = {16'h0, pad_ff};
      ADDR_COUNT:     rd_mux = {18'h0, cnt_ff};
      ADDR_LAST_HIGH: rd_mux = {24'h0, last_ff[23:16]};
      ADDR_LAST_LOW:  rd_mux = {16'h0, last_ff[15:0]};
      ADDR_STATUS:    rd_mux = {16'h0, 2'b00, done_ff};
      default:        rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= RESET_ZERO;
      s_axi_rresp_o   <= RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_mux;
        s_axi_rresp_o   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
endmodule : dmacra_channel

// ---- dmacra_mem_model.sv ----
`timescale 1ns/100ps
module dmacra_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic        is_ram_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [2:0]  delay_i,
  output logic             ack_o,
  output logic [15:0]      rdata_o,
  output int               wr_cnt_o,
  output logic [32:0]      last_wr_o
);
  logic [2:0] wait_ff;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_ff   <= 3'h0;
      ack_o     <= 1'b0;
      rdata_o   <= 16'h0000;
      wr_cnt_o  <= 0;
      last_wr_o <= '0;
    end else begin
      ack_o   <= 1'b0;
      // Released data lines toggle so stale data never looks valid
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        if (wait_ff >= delay_i) begin
          ack_o   <= 1'b1;
          wait_ff <= 3'h0;
          if (write_i) begin
            wr_cnt_o  <= wr_cnt_o + 1;
            last_wr_o <= {is_ram_i, addr_i[15:0], wdata_i};
          end else begin
            rdata_o <= addr_i[15:0] ^ 16'h5A5A;
          end
        end else begin
          wait_ff <= wait_ff + 3'h1;
        end
      end
    end
  end
endmodule : dmacra_mem_model

// ---- dmacra_channel_asserts.sv ----
`timescale 1ns/100ps
module dmacra_channel_asserts
  import dmacra_pkg::*;
(
  input wire logic                      clk_sys_i,
  input wire logic                      rst_n_i,
  input wire logic                      s_axi_bvalid_o,
  input wire logic                      s_axi_bready_i,
  input wire logic [1:0]                s_axi_bresp_o,
  input wire logic                      s_axi_rvalid_o,
  input wire logic                      s_axi_rready_i,
  input wire logic [31:0]               s_axi_rdata_o,
  input wire logic                      mem_req_o,
  input wire logic                      mem_write_o,
  input wire logic                      mem_is_ram_o,
  input wire logic [dmacra_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [15:0]               mem_wdata_o,
  input wire logic                      mem_ack_i,
  input wire logic [15:0]               mem_rdata_i,
  input wire logic                      block_done_o,
  input wire logic                      busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] rd_ff;
  logic        side_ff;
  // Data and side of the last completed read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ff   <= 16'h0000;
      side_ff <= 1'b0;
    end else if (mem_req_o && mem_ack_i && !mem_write_o) begin
      rd_ff   <= mem_rdata_i;
      side_ff <= mem_is_ram_o;
    end
  end
  AST_REQ_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_write_o))
    else $error("memory request changed before ack");
  AST_READ_THEN_WRITE: assert property (mem_req_o && mem_ack_i && !mem_write_o |=> ##[0:3] mem_req_o && mem_write_o)
    else $error("read not followed by write");
  AST_WDATA_COPY: assert property (mem_req_o && mem_write_o |-> mem_wdata_o == rd_ff)
    else $error("written data differs from read data");
  AST_SIDE_SWAP: assert property (mem_req_o && mem_write_o |-> mem_is_ram_o != side_ff)
    else $error("write on same side as read");
  AST_BUSY_COVERS_REQ: assert property (mem_req_o |-> busy_o)
    else $error("memory request while not busy");
  AST_DONE_PULSE: assert property (block_done_o |=> !block_done_o)
    else $error("block done longer than one cycle");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  COV_WRITE: cover property (mem_req_o && mem_write_o && mem_ack_i);
  COV_DONE: cover property (block_done_o);
  COV_ERR: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule : dmacra_channel_asserts
bind dmacra_channel dmacra_channel_asserts u_asserts (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .mem_req_o(mem_req_o), .mem_write_o(mem_write_o), .mem_is_ram_o(mem_is_ram_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .block_done_o(block_done_o),
  .busy_o(busy_o));

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import dmacra_pkg::*;
  localparam logic [7:0] CODE [21] = '{8'h00, 8'h01, 8'h05, 8'h25, 8'h26, 8'h02, 8'h06, 8'h19, 8'h1A, 8'h07, 8'h08,
    8'h1B, 8'h1C, 8'h0B, 8'h0C, 8'h1E, 8'h1F, 8'h22, 8'h46, 8'h37, 8'h47};
  localparam logic [31:0] MSK [7] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_FFFF, 32'h0000_00FF, 32'h0000_FFFF,
    32'h0000_FFFF, 32'h0000_3FFF};
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, oth = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [22:0] ev = '0;
  logic [23:0] oth_addr = 24'h00_0000;
  logic [2:0]  dly = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, req, wr, ram, ack;
  logic [1:0]  bresp;
  logic [31:0] rdata, d;
  logic [23:0] maddr;
  logic [15:0] mwdata, mrdata;
  logic [32:0] last_wr;
  logic [1:0]  r, rrsp;
  logic        done;
  int          n_done = 0;
  int          wr_cnt, i;
  int          fails = 0;
  int          n_tests = 0;

  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  dmacra_channel dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rrsp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .periph_event_i(ev),
    .other_ram_access_i(oth), .other_ram_addr_i(oth_addr), .mem_req_o(req), .mem_write_o(wr), .mem_is_ram_o(ram),
    .mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_ack_i(ack), .mem_rdata_i(mrdata), .block_done_o(done), .busy_o());
  dmacra_mem_model u_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req), .write_i(wr), .is_ram_i(ram),
    .addr_i(maddr), .wdata_i(mwdata), .delay_i(dly), .ack_o(ack), .rdata_o(mrdata), .wr_cnt_o(wr_cnt),
    .last_wr_o(last_wr));

  always @(posedge clk_sys_i) begin
    if (done) n_done <= n_done + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic lim(input int k);
    if (k >= 50) begin
      fails++;
      report_and_stop();
    end
  endtask : lim

  task automatic axw(input logic [5:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    int k;
    logic ah, wh, ap, wp;
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    for (k = 0; k < 50 && (ap || wp); k++) begin
      @(negedge clk_sys_i);
      ah = awready && ap;
      wh = wready && wp;
      @(posedge clk_sys_i);
      if (ah) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wh) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    lim(k);
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys_i);
      if (bvalid) break;
    end
    lim(k);
    rsp = bresp;
    @(posedge clk_sys_i);
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [5:0] a, output logic [31:0] dat);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys_i);
      if (arready) break;
    end
    lim(k);
    @(posedge clk_sys_i);
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys_i);
      if (rvalid) break;
    end
    lim(k);
    dat = rdata;
    @(posedge clk_sys_i);
    rready <= 1'b0;
  endtask : axr

  task automatic cfg(input logic [23:0] a, input logic [13:0] cnt, input logic [3:0] ctl);
    axw(ADDR_CTRL, 32'h0000_0000, r);
    axw(ADDR_PRI_HIGH, {24'h0, a[23:16]}, r);
    axw(ADDR_PRI_LOW, {16'h0, a[15:0]}, r);
    axw(ADDR_COUNT, {18'h0, cnt}, r);
    axw(ADDR_CTRL, {28'h0, ctl}, r);
  endtask : cfg

  task automatic pulse(input int n);
    ev[n] <= 1'b1;
    @(posedge clk_sys_i);
    ev <= '0;
    @(posedge clk_sys_i);
  endtask : pulse

  task automatic wt(input int n);
    int k;
    for (k = 0; k < 200 && wr_cnt < n; k++) @(posedge clk_sys_i);
    if (k == 200) lim(50);
    repeat (4) @(posedge clk_sys_i);
    chk("writes", n, wr_cnt);
  endtask : wt

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (i = 1; i < 11; i++) begin
      axr(6'(4 * i), d);
      chk("reset value", 0, d);
    end
    for (i = 0; i < 7; i++) begin
      axw(6'(4 * i + 4), 32'hFFFF_FFFF, r);
      axr(6'(4 * i + 4), d);
      chk("field mask", MSK[i], d);
    end
    axw(ADDR_LAST_HIGH, 32'hFFFF_FFFF, r);
    chk("read-only resp", RESP_SLVERR, r);
    axr(ADDR_LAST_HIGH, d);
    chk("read-only kept", 0, d);
    axw(6'h3C, 32'h0000_0001, r);
    chk("unmapped resp", RESP_SLVERR, r);
    axr(6'h3C, d);
    chk("unmapped read resp", RESP_SLVERR, rrsp);
    dly <= 3'h3;
    axw(ADDR_PERIPH, 32'h0000_0800, r);
    cfg(24'h12_0040, 14'h0, 4'h3);
    axw(ADDR_REQ_SEL, 32'h0000_8003, r);
    wt(1);
    chk("forced write", {1'b0, 16'h0800, 16'h5A1A}, last_wr);
    for (i = 0; i < 23; i++) pulse(i);
    wt(1);
    axr(ADDR_REQ_SEL, d);
    chk("trigger cleared", 32'h0000_0003, d);
    axr(ADDR_LAST_HIGH, d);
    chk("last high", 32'h0000_0012, d);
    axr(ADDR_LAST_LOW, d);
    chk("last low", 32'h0000_0040, d);
    dly <= 3'h0;
    axw(ADDR_CTRL, 32'h0000_0001, r);
    for (i = 0; i < 21; i++) begin
      axw(ADDR_REQ_SEL, {24'h0, CODE[i]}, r);
      pulse((i + 1) % 21);
      pulse(i);
      wt(i + 2);
    end
    chk("periph to ram", {1'b1, 16'h0040, 16'h525A}, last_wr);
    dly <= 3'h5;
    cfg(24'h00_0040, 14'h2, 4'h5);
    for (i = 0; i < 4; i++) begin
      pulse(20);
      wt(23 + (i < 3 ? i : 2));
    end
    chk("block end address", {1'b1, 16'h0042, 16'h525A}, last_wr);
    axr(ADDR_CTRL, d);
    chk("one-shot enable", 0, d[0]);
    chk("blocks done", 23, n_done);
    axw(ADDR_SEC_HIGH, 32'h0000_0000, r);
    axw(ADDR_SEC_LOW, 32'h0000_0200, r);
    cfg(24'h00_0100, 14'h0, 4'h9);
    for (i = 0; i < 3; i++) begin
      pulse(20);
      wt(26 + i);
      chk("ping-pong", {1'b1, (i == 1 ? 16'h0200 : 16'h0100), 16'h525A}, last_wr);
    end
    axw(ADDR_CTRL, 32'h0000_0000, r);
    pulse(20);
    wt(28);
    oth <= 1'b1;
    oth_addr <= 24'h34_5678;
    @(posedge clk_sys_i);
    oth <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    axr(ADDR_LAST_LOW, d);
    chk("other channel", 32'h0000_5678, d);
    report_and_stop();
  end
endmodule : testbench
